/* src/ros_clk_switch.sv */
/*
 * Glitch-free selection between the loop clock and the external master
 * clock, both seen as levels sampled on the internal clock.
 * Assumes both source clocks are well below half the internal rate.
 */
`timescale 1ns/100ps
module ros_clk_switch (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // Source levels and selection request
  input  wire logic pll_lvl_in,
  input  wire logic ext_lvl_in,
  input  wire logic use_ext_in,
  // Selected clock and current selection
  output logic      mclk_out,
  output logic      sel_ext_out
);
  logic nxt_sel;       // Next selection
  logic new_low;       // Requested source is low
  logic can_switch;    // Safe point for a change

  ////////////////////////////////////////////////////////////////////////
  // Change only while output and the new source are both low
  assign new_low    = use_ext_in ? !ext_lvl_in : !pll_lvl_in;
  assign can_switch = (use_ext_in != sel_ext_out) && !mclk_out && new_low;
  assign nxt_sel    = can_switch ? use_ext_in : sel_ext_out;

  // Selection and output flops
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sel_ext_out <= 1'b0;
      mclk_out    <= 1'b0;
    end else begin
      sel_ext_out <= nxt_sel;
      mclk_out    <= nxt_sel ? ext_lvl_in : pll_lvl_in;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_switch_when_low: assert property ($changed(sel_ext_out) |-> !$past(mclk_out))
    else $error("Clock source changed while output was high");
  c_switch_ext: cover property ($rose(sel_ext_out));
endmodule : ros_clk_switch

/* src/ros_pkg.sv */
/*
 * Constants for the receiver output timing block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes the internal clock runs at 256 times the sample rate.
 */
package ros_pkg;
  // Register offsets
  localparam logic [7:0] CTRL0_OFS     = 8'h00;  // Forced switch control
  localparam logic [7:0] CTRL1_OFS     = 8'h01;  // Switch enable, mute
  localparam logic [7:0] INSEL_OFS     = 8'h04;  // input_select_control
  localparam logic [7:0] SFMT_OFS      = 8'h05;  // serial_format_control
  localparam logic [7:0] ISTAT1_OFS    = 8'h0D;  // interrupt_status_one

  // Field positions
  localparam int FORCE_SW_BIT  = 3;  // Control 0: forced_clock_switch
  localparam int SW_EN_BIT     = 7;  // Control 1: auto switch enable
  localparam int MUTE_BIT      = 4;  // Control 1: serial_output_mute
  localparam int DECODER_INPUT_SELECT_LSB     = 3;  // decoder_input_select [5:3]
  localparam int PASSTHROUGH_SELECT_LSB     = 0;  // passthrough_select [2:0]
  localparam int MASTER_BIT    = 7;  // Serial format: master mode
  localparam int RJUST_BIT     = 2;  // Serial format: right justified
  localparam int POL_BIT       = 0;  // Serial format: frame_clock_polarity
  localparam int SLIP_BIT      = 5;  // Status 1: slip_repeat_flag

  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] INSEL_RST  = 8'h00;  // Decoder input zero
  localparam logic [7:0] SFMT_RST   = 8'h00;

  // Timing: one sample period in internal clock cycles
  localparam int FS_PERIOD_CYC = 256;
  // Look-back delay after a preamble, in internal cycles
  localparam int CHECK_DLY_CYC = 4;
  // Same-instant window in percent of a sample period, and in cycles
  localparam int SAME_WIN_PCT  = 28;
  localparam int SAME_WIN_CYC  = (FS_PERIOD_CYC * SAME_WIN_PCT) / 100;
  // Frame alignment: divider preset that makes the active edge now
  localparam logic [7:0] DIV_ALIGN  = 8'h80;
  localparam int BCLK_DIV_BIT  = 1;  // Master clock / 4
  localparam int FCLK_DIV_BIT  = 7;  // Master clock / 256

  localparam int SAMPLE_W      = 24;
endpackage : ros_pkg

/* src/ros_top.sv */
/*
 * Receiver output timing: slip/repeat detection against a slave frame
 * clock, frame clock alignment and latency in master mode, input and
 * pass-through selection, and master clock substitution on unlock.
 * Assumes a 256Fs internal clock, synchronous pins, and a preamble pulse
 * with its decoded sample from the decoder.
 */
// Summary of operation
// - Check interval shortly after each Z/X preamble
// - No frame edge: drop frame, set flag
// - Buffer not updated: repeat frame, set flag
// - Flag is bit 5 of status 0Dh
// - Flag sticky until register is read
// - One edge seen: flag left unchanged
// - Active edge rising, falling if polarity set
// - Hysteresis stops jitter giving repeated events
// - Locked master (loop clock selected): frame edge aligned to preamble start
// - Master latency is two frames
// - Slave inputs near edge sampled together
// - Software mode: 3-bit decoder input select
// - Decoder input select resets to zero
// - Software mode: 3-bit pass-through select
// - Hardware mode: pins select inputs 0-3
// - Glitch-free external clock substitution on unlock
// - Hardware: external clock edge enables switching
// - Software: enable bit allows automatic switching
// - Forced bit always selects external clock
// - Switched master: frame /256, bit /4
// - Switching off, forced bit clear: clocks stay on loop clock
// - Master drives clocks, slave receives them
// - Slave mode forbids right justification
`timescale 1ns/100ps
module ros_top (
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          sys_rst_in,
  // Register port
  input  wire logic [7:0]                    reg_addr_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  input  wire logic [7:0]                    reg_wdata_in,
  output logic      [7:0]                    reg_rdata_out,
  // Mode and hardware select pins
  input  wire logic                          hw_mode_in,
  input  wire logic [1:0]                    hw_rx_sel_in,
  input  wire logic [1:0]                    hw_tx_sel_in,
  // Receive inputs and multiplexer outputs
  input  wire logic [7:0]                    receive_input_pos_in,
  output logic                               decoder_input_out,
  output logic                               gpo_passthru_out,
  output logic                               tx_passthru_out,
  // Clocks in and recovered clock out
  input  wire logic                          pll_clk_in,
  input  wire logic                          pll_lock_in,
  input  wire logic                          external_master_clock_in,
  output logic                               recovered_master_clock_out,
  // Decoder frame stream
  input  wire logic                          preamble_in,
  input  wire logic [ros_pkg::SAMPLE_W-1:0]  sample_in,
  // Serial port clocks (two-way)
  input  wire logic                          output_frame_clock_in,
  output logic                               output_frame_clock_out,
  output logic                               output_frame_clock_oe_out,
  input  wire logic                          output_bit_clock_in,
  output logic                               output_bit_clock_out,
  output logic                               output_bit_clock_oe_out,
  // Serial port data side
  output logic      [ros_pkg::SAMPLE_W-1:0]  sample_out,
  output logic                               right_justified_out
);
  // Register flops
  logic [7:0] ctrl0_ff, ctrl1_ff, insel_ff, sfmt_ff;
  logic       slip_flag_ff;                   // slip_repeat_flag
  logic       hw_en_ff;                       // Hardware switch enable
  logic       ext_prev_ff;                    // Last external clock level
  // Clocking and frame state
  logic [7:0] div_cnt_ff;                     // Master clock divider
  logic       mclk_prev_ff;                   // Last recovered clock level
  logic       frm_prev_ff;                    // Last frame clock level
  logic [2:0] chk_cnt_ff;                     // Look-back delay count
  logic [1:0] edge_cnt_ff;                    // Active edges this interval
  logic       hold_ff;                        // Hysteresis hold-off
  logic [7:0] win_cnt_ff;                     // Same-instant window count
  logic [ros_pkg::SAMPLE_W-1:0] buf_ff;       // Output buffer
  logic [ros_pkg::SAMPLE_W-1:0] pipe_ff [0:1];// Master latency stages
  logic       sel_ext;                        // From the clock switch
  logic       mclk_sel;                       // Selected clock level
  // Decoded controls
  wire        master    = sfmt_ff[ros_pkg::MASTER_BIT];
  wire        pol       = sfmt_ff[ros_pkg::POL_BIT];
  wire        mute      = ctrl1_ff[ros_pkg::MUTE_BIT];
  wire        forced    = ctrl0_ff[ros_pkg::FORCE_SW_BIT];
  wire        sw_en     = hw_mode_in ? hw_en_ff : ctrl1_ff[ros_pkg::SW_EN_BIT];
  wire        use_ext   = forced || (sw_en && !pll_lock_in);
  wire        wr_hit    = reg_wr_in;
  wire        rd_clr    = reg_rd_in && (reg_addr_in == ros_pkg::ISTAT1_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Input multiplexers
  wire [2:0] rx_idx = hw_mode_in ? {1'b0, hw_rx_sel_in}
                                 : insel_ff[ros_pkg::DECODER_INPUT_SELECT_LSB +: 3];
  wire [2:0] tx_idx = hw_mode_in ? {1'b0, hw_tx_sel_in}
                                 : insel_ff[ros_pkg::PASSTHROUGH_SELECT_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////
  // Frame clock edge detection and the look-back check
  wire frm_lvl    = master ? output_frame_clock_out : output_frame_clock_in;
  wire act_edge   = ((frm_lvl ^ pol) && !(frm_prev_ff ^ pol));
  wire chk_now    = (chk_cnt_ff == 3'(1));
  wire slip_evt   = chk_now && !master && !hold_ff
                    && (edge_cnt_ff == 2'd0);
  wire rep_evt    = chk_now && !master && !hold_ff
                    && (edge_cnt_ff >= 2'd2);
  wire any_evt    = slip_evt || rep_evt;
  wire mclk_rise  = recovered_master_clock_out && !mclk_prev_ff;
  wire ext_rise   = external_master_clock_in && !ext_prev_ff;
  // Locked loop runs at the internal rate; otherwise count source rises
  wire div_step   = (pll_lock_in && !sel_ext) || mclk_rise;
  wire late_smpl  = preamble_in && !master && (win_cnt_ff != 8'd0);

  ////////////////////////////////////////////////////////////////////////
  // Register read data
  wire [7:0] rd_mux =
    (reg_addr_in == ros_pkg::CTRL0_OFS)  ? ctrl0_ff :
    (reg_addr_in == ros_pkg::CTRL1_OFS)  ? ctrl1_ff :
    (reg_addr_in == ros_pkg::INSEL_OFS)  ? insel_ff :
    (reg_addr_in == ros_pkg::SFMT_OFS)   ? sfmt_ff  :
    (reg_addr_in == ros_pkg::ISTAT1_OFS) ? (8'(slip_flag_ff) << ros_pkg::SLIP_BIT) :
    8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Glitch-free master clock selection
  ros_clk_switch u_clk_switch (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .pll_lvl_in  (pll_clk_in),
    .ext_lvl_in  (external_master_clock_in),
    .use_ext_in  (use_ext),
    .mclk_out    (mclk_sel),
    .sel_ext_out (sel_ext)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control registers and read data
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctrl0_ff      <= ros_pkg::CTRL_RST;
      ctrl1_ff      <= ros_pkg::CTRL_RST;
      insel_ff      <= ros_pkg::INSEL_RST;
      sfmt_ff       <= ros_pkg::SFMT_RST;
      reg_rdata_out <= 8'h00;
    end else begin
      if (wr_hit && reg_addr_in == ros_pkg::CTRL0_OFS) ctrl0_ff <= reg_wdata_in;
      if (wr_hit && reg_addr_in == ros_pkg::CTRL1_OFS) ctrl1_ff <= reg_wdata_in;
      if (wr_hit && reg_addr_in == ros_pkg::INSEL_OFS) insel_ff <= reg_wdata_in;
      if (wr_hit && reg_addr_in == ros_pkg::SFMT_OFS)  sfmt_ff  <= reg_wdata_in;
      // Read data stands until the next read
      if (reg_rd_in) reg_rdata_out <= rd_mux;
    end
  end

  // Sticky slip/repeat flag; a new event wins over the read clear
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      slip_flag_ff <= 1'b0;
    end else if (any_evt) begin
      slip_flag_ff <= 1'b1;
    end else if (rd_clr) begin
      slip_flag_ff <= 1'b0;
    end
  end

  // Hardware switch enable: first external clock rise, kept to reset
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hw_en_ff    <= 1'b0;
      ext_prev_ff <= 1'b1;
    end else begin
      ext_prev_ff <= external_master_clock_in;
      if (ext_rise) hw_en_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Look-back timer, edge count and hysteresis hold-off
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      chk_cnt_ff  <= 3'd0;
      edge_cnt_ff <= 2'd0;
      hold_ff     <= 1'b0;
      frm_prev_ff <= 1'b0;
    end else begin
      frm_prev_ff <= frm_lvl;
      // Start the fixed delay on each preamble
      if (preamble_in) begin
        chk_cnt_ff <= 3'(ros_pkg::CHECK_DLY_CYC);
      end else if (chk_cnt_ff != 3'd0) begin
        chk_cnt_ff <= chk_cnt_ff - 3'd1;
      end
      // Count edges since the last check, saturating at two
      if (chk_now) begin
        edge_cnt_ff <= act_edge ? 2'd1 : 2'd0;
      end else if (act_edge && edge_cnt_ff != 2'd2) begin
        edge_cnt_ff <= edge_cnt_ff + 2'd1;
      end
      // After an event, the next interval cannot trigger again
      if (chk_now) hold_ff <= any_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output buffer, latency stages and output sample
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      buf_ff     <= '0;
      pipe_ff[0] <= '0;
      pipe_ff[1] <= '0;
      sample_out <= '0;
    end else begin
      // Second update before an edge overwrites: frame dropped
      if (preamble_in) buf_ff <= sample_in;
      if (act_edge) begin
        pipe_ff[0] <= buf_ff;
        pipe_ff[1] <= pipe_ff[0];
        // No update since the last edge: same word goes out again
        sample_out <= mute ? '0 : (master ? pipe_ff[1] : buf_ff);
      end else if (late_smpl) begin
        sample_out <= mute ? '0 : sample_in;
      end
    end
  end

  // Same-instant window opened by each slave edge
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      win_cnt_ff <= 8'd0;
    end else if (act_edge) begin
      win_cnt_ff <= 8'(ros_pkg::SAME_WIN_CYC);
    end else if (win_cnt_ff != 8'd0) begin
      win_cnt_ff <= win_cnt_ff - 8'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master clock divider, preamble alignment and serial clock pins
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_cnt_ff   <= 8'd0;
      mclk_prev_ff <= 1'b0;
      recovered_master_clock_out <= 1'b0;
      output_frame_clock_out     <= 1'b0;
      output_bit_clock_out       <= 1'b0;
      output_frame_clock_oe_out  <= 1'b0;
      output_bit_clock_oe_out    <= 1'b0;
    end else begin
      recovered_master_clock_out <= mclk_sel;
      mclk_prev_ff <= recovered_master_clock_out;
      // Locked master: active edge follows the preamble start
      if (master && preamble_in && pll_lock_in && !sel_ext) begin
        div_cnt_ff <= ros_pkg::DIV_ALIGN;
      end else if (div_step) begin
        div_cnt_ff <= div_cnt_ff + 8'd1;
      end
      output_frame_clock_out <= div_cnt_ff[ros_pkg::FCLK_DIV_BIT] ^ pol;
      output_bit_clock_out   <= div_cnt_ff[ros_pkg::BCLK_DIV_BIT];
      output_frame_clock_oe_out <= master;
      output_bit_clock_oe_out   <= master;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Multiplexer outputs and serial format flag
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      decoder_input_out   <= 1'b0;
      gpo_passthru_out    <= 1'b0;
      tx_passthru_out     <= 1'b0;
      right_justified_out <= 1'b0;
    end else begin
      decoder_input_out   <= receive_input_pos_in[rx_idx];
      gpo_passthru_out    <= !hw_mode_in && receive_input_pos_in[tx_idx];
      tx_passthru_out     <= hw_mode_in && receive_input_pos_in[tx_idx];
      right_justified_out <= master && sfmt_ff[ros_pkg::RJUST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_slip_sets_flag: assert property (slip_evt |=> slip_flag_ff)
    else $error("Slip did not set flag");
  a_repeat_sets_flag: assert property (rep_evt |=> slip_flag_ff)
    else $error("Repeat did not set flag");
  a_flag_bit_five: assert property (reg_rd_in && rd_clr && slip_flag_ff
    |=> reg_rdata_out == 8'h20)
    else $error("Flag not read at bit 5");
  a_flag_read_clear: assert property (rd_clr && !any_evt |=> !slip_flag_ff)
    else $error("Read did not clear flag");
  a_flag_hold_none: assert property (chk_now && edge_cnt_ff == 2'd1 && !rd_clr
    |=> $stable(slip_flag_ff))
    else $error("Flag changed with one edge");
  a_hyst_one_event: assert property (chk_now && hold_ff |-> !any_evt)
    else $error("Back-to-back slip events");
  a_master_align: assert property (master && preamble_in && pll_lock_in && !sel_ext
    && $stable(pol) |-> ##2 (output_frame_clock_out != pol))
    else $error("Frame edge not aligned to preamble");
  a_rx_reset_zero: assert property ($fell(sys_rst_in) |-> insel_ff[5:3] == 3'd0)
    else $error("Decoder select not zero after reset");
  a_hw_sel_range: assert property (hw_mode_in |-> rx_idx < 3'd4 && tx_idx < 3'd4)
    else $error("Hardware select outside inputs 0-3");
  a_hw_en_sticky: assert property (hw_en_ff |=> hw_en_ff)
    else $error("Hardware switch enable dropped");
  a_forced_ext: assert property (forced [*8] |-> sel_ext)
    else $error("Forced switch ignored");
  a_slave_no_rj: assert property (!master |=> !right_justified_out)
    else $error("Right justified in slave mode");

  c_slip: cover property (slip_evt);
  c_repeat: cover property (rep_evt);
  c_hw_enable: cover property ($rose(hw_en_ff));
  c_master_edge: cover property (master && act_edge);
endmodule : ros_top

/* testbench/ros_frame_src.sv */
/*
 * Far-side model: an audio processor that supplies the slave frame clock.
 * Assumes the bench sets the half period in internal clock cycles.
 */
`timescale 1ns/100ps
module ros_frame_src (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // Half period, zero stops the clock
  input  wire logic [8:0] half_in,
  // Frame clock towards the device
  output logic            fclk_out
);
  logic [8:0] cnt_ff;  // Cycles into current phase

  ////////////////////////////////////////////////////////////////
  // Free-running divider; the far side drives only the frame clock
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || half_in == 9'h000) begin
      cnt_ff   <= 9'h000;
      fclk_out <= 1'b0;
    end else if (cnt_ff >= half_in - 9'h001) begin
      cnt_ff   <= 9'h000;
      fclk_out <= ~fclk_out;
    end else begin
      cnt_ff <= cnt_ff + 9'h001;
    end
  end
endmodule : ros_frame_src

/* testbench/test_receiver_output_sync_clock_switch.sv */
/*
 * Bench for ros_top: registers, muxes, serial modes, slip flag, clock switch.
 * Assumes ros_frame_src supplies the slave frame clock.
 */
`timescale 1ns/100ps
module test_receiver_output_sync_clock_switch;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, hw = 1'b0;
  logic [7:0]  addr = 8'h00, wdat = 8'h00, rx = 8'h00, cyc = 8'h00, rdat, d;
  logic [1:0]  hrx = 2'h0, htx = 2'h0;
  logic        pclk = 1'b0, lock = 1'b1, eclk = 1'b0, pre = 1'b0;
  logic [23:0] smp = 24'h00_0000;
  logic [8:0]  half = 9'h000;
  logic        mck, fclk, fo, foe, dec, gpo, txp, rj, bo, boe;
  logic [23:0] so;
  logic [23:0] sh [3];  // Last three master samples sent
  wire         fpin = foe ? fo : fclk;  // Shared frame clock pin
  int          n_mismatch = 0, check_count = 0, i, k;
  logic [7:0]  ra [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h0D, 8'h3C};
  logic [7:0]  fm [3] = '{8'h04, 8'h84, 8'h00};
  logic [8:0]  hp [3] = '{9'h000, 9'h040, 9'h080};
  logic [17:0] cs [5] = '{18'h1_0000, 18'h1_0800, 18'h0_0080, 18'h0_0000, 18'h2_0000};

  ////////////////////////////////////////////////////////////////
  // Clock, source clocks (external period 8, loop period 4)
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc  <= cyc + 8'h01;
    eclk <= cyc[2];
    pclk <= cyc[1];
  end

  ros_top dut (.ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdat), .reg_rdata_out(rdat), .hw_mode_in(hw),
    .hw_rx_sel_in(hrx), .hw_tx_sel_in(htx), .receive_input_pos_in(rx),
    .decoder_input_out(dec), .gpo_passthru_out(gpo), .tx_passthru_out(txp),
    .pll_clk_in(pclk), .pll_lock_in(lock), .external_master_clock_in(eclk),
    .recovered_master_clock_out(mck), .preamble_in(pre), .sample_in(smp),
    .output_frame_clock_in(fpin), .output_frame_clock_out(fo),
    .output_frame_clock_oe_out(foe), .output_bit_clock_in(1'b0),
    .output_bit_clock_out(bo), .output_bit_clock_oe_out(boe), .sample_out(so),
    .right_justified_out(rj));
  ros_frame_src frame_src (.ref_clk_in(clk), .sys_rst_in(rst), .half_in(half),
    .fclk_out(fclk));

  ////////////////////////////////////////////////////////////////
  // Compare, register access, frame stream
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdat <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdat;
  endtask : rreg
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk);
      pre <= 1'b1; smp <= 24'($urandom);
      @(posedge clk);
      pre <= 1'b0;
      repeat (254) @(posedge clk);
    end
  endtask : frames
  // Rises in 64 cycles of the recovered clock (b=0) or bit clock (b=1)
  task automatic rises(input bit b, output int n);
    logic p;
    n = 0;
    for (int c = 0; c < 64; c++) begin
      p = b ? bo : mck;
      @(posedge clk);
      n += int'((b ? bo : mck) === 1'b1 && p === 1'b0);
    end
  endtask : rises
  // Equal frame and preamble periods give one edge per interval
  function automatic logic [7:0] slip_exp(input logic [8:0] h);
    return (h == 9'h080) ? 8'h00 : 8'(1 << ros_pkg::SLIP_BIT);
  endfunction : slip_exp
  // Rises in 64 cycles: 8 on the external clock, 16 on the loop clock
  // Bit 17 is hardware mode, where the external clock has already risen
  function automatic logic [7:0] rise_exp(input logic [17:0] c);
    return (c[8 + ros_pkg::FORCE_SW_BIT] || ((c[17] || c[ros_pkg::SW_EN_BIT]) && !c[16]))
           ? 8'h08 : 8'h10;
  endfunction : rise_exp
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hd9e1a9c4));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wreg(8'h0D, 8'hFF);  // Status is read-only
    foreach (ra[j]) begin
      rreg(ra[j], d);
      check(d, 8'h00);
    end
    $display("test done: reset values");
    for (i = 0; i < 8; i++) begin
      wreg(ros_pkg::INSEL_OFS, 8'((i << ros_pkg::DECODER_INPUT_SELECT_LSB) | ((7 - i) << ros_pkg::PASSTHROUGH_SELECT_LSB)));
      rx <= 8'($urandom);
      repeat (4) @(posedge clk);
      check(8'(dec), 8'(rx[i]));
      check(8'(gpo), 8'(rx[7 - i]));
      check(8'(txp), 8'h00);
    end
    hw <= 1'b1;
    for (i = 0; i < 4; i++) begin
      hrx <= 2'(i); htx <= 2'(3 - i); rx <= 8'($urandom);
      repeat (4) @(posedge clk);
      check(8'(dec), 8'(rx[i]));
      check(8'(txp), 8'(rx[3 - i]));
      check(8'(gpo), 8'h00);
    end
    hw <= 1'b0;
    $display("test done: input select");
    foreach (fm[j]) begin
      wreg(ros_pkg::SFMT_OFS, fm[j]);
      repeat (3) @(posedge clk);
      check(8'(rj), 8'(fm[j][7] & fm[j][2]));
      check(8'(foe), 8'(fm[j][7]));
      check(8'(boe), 8'(fm[j][7]));
    end
    $display("test done: serial modes");
    foreach (hp[j]) begin
      half <= hp[j];
      frames(4);
      rreg(ros_pkg::ISTAT1_OFS, d);
      frames(6);
      rreg(ros_pkg::ISTAT1_OFS, d);
      check(d, slip_exp(hp[j]));
      rreg(ros_pkg::ISTAT1_OFS, d);
      check(d, 8'h00);
    end
    half <= 9'h000;
    $display("test done: slip flag");
    // Master: sample sent at frame n leaves on the edge of frame n+2
    wreg(ros_pkg::SFMT_OFS, 8'h80);
    for (i = 0; i < 6; i++) begin
      frames(1);
      sh[2] = sh[1];
      sh[1] = sh[0];
      sh[0] = smp;
      if (i >= 3) check(so, sh[2]);
    end
    wreg(ros_pkg::CTRL1_OFS, 8'h10);
    frames(1);
    check(so, 24'h00_0000);
    $display("test done: master frames");
    foreach (cs[j]) begin
      wreg(ros_pkg::CTRL0_OFS, cs[j][15:8]);
      wreg(ros_pkg::CTRL1_OFS, cs[j][7:0]);
      lock <= cs[j][16];
      hw   <= cs[j][17];
      repeat (32) @(posedge clk);
      rises(1'b0, k);
      check(8'(k), rise_exp(cs[j]));
      rises(1'b1, k);
      check(8'(k), (rise_exp(cs[j]) == 8'h08) ? 8'h02 : (cs[j][16] ? 8'h10 : 8'h04));
    end
    $display("test done: clock switch");
    tally_and_finish();
  end

  // Guard against a hang
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : test_receiver_output_sync_clock_switch
